// File: rtl/can_mode_pkg.sv
// Shared modes, encodings and timing constants of the CAN transceiver mode logic
package can_mode_pkg;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {
    CAN_OFF    = 2'h0,
    CAN_WAKE   = 2'h1,
    CAN_RXONLY = 2'h2,
    CAN_NORMAL = 2'h3
  } can_mode_t;

  typedef enum logic [2:0] {
    SYS_NORMAL   = 3'h0,
    SYS_STOP     = 3'h1,
    SYS_SLEEP    = 3'h2,
    SYS_RESTART  = 3'h3,
    SYS_FAILSAFE = 3'h4
  } sys_mode_t;

  localparam can_mode_t RESET_MODE = CAN_OFF;
  localparam int SYS_MODE_W = 3;
  localparam int CNT_W = 16;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  // Least time, rounded up
  localparam int TX_EN_NS = 20000;
  localparam int TX_EN_CYC = (TX_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Wake phase bounds: least rounds up, longest rounds down
  localparam int WAKE_MIN_NS = 500;
  localparam int WAKE_MIN_CYC = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_MAX_NS = 1000000;
  localparam int WAKE_MAX_CYC = WAKE_MAX_NS / CLK_PERIOD_NS;

endpackage : can_mode_pkg

// File: rtl/pair_buffer.sv
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module pair_buffer #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  if (DEPTH != 2 || WIDTH < 1) begin : g_bad_param
    $error("pair_buffer supports DEPTH 2 and WIDTH of at least 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic wr_q;
  logic rd_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != 2'h2);
  assign out_valid_o = (count_q != 2'h0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  // Read data straight from the entry register
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : pair_buffer

// File: rtl/wake_detector.sv
// Bus wake pattern detector: dominant, recessive, dominant phases
`timescale 1ns/1ps
module wake_detector #(
  parameter int MIN_CYC = can_mode_pkg::WAKE_MIN_CYC,
  parameter int MAX_CYC = can_mode_pkg::WAKE_MAX_CYC
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  input wire logic bus_dom_i,
  output logic wake_o
);
  if (MIN_CYC < 1 || MAX_CYC >= 65536 || MIN_CYC >= MAX_CYC) begin : g_bad_param
    $error("wake_detector needs 1 <= MIN_CYC < MAX_CYC < 65536");
  end

  typedef enum logic [1:0] {
    W_IDLE = 2'h0,
    W_DOM1 = 2'h1,
    W_REC  = 2'h2,
    W_DOM2 = 2'h3
  } wake_st_t;

  localparam logic [can_mode_pkg::CNT_W-1:0] MIN_V = can_mode_pkg::CNT_W'(MIN_CYC);
  localparam logic [can_mode_pkg::CNT_W-1:0] MAX_V = can_mode_pkg::CNT_W'(MAX_CYC);

  wake_st_t st_q;
  logic [can_mode_pkg::CNT_W-1:0] cnt_q;

  // A phase that ends too short or runs too long restarts the search
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= W_IDLE;
      cnt_q <= '0;
      wake_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
      if (!enable_i) begin
        st_q <= W_IDLE;
        cnt_q <= '0;
      end else begin
        unique case (st_q)
          W_IDLE: begin
            cnt_q <= '0;
            if (bus_dom_i) begin
              st_q <= W_DOM1;
            end
          end
          W_DOM1: begin
            if (!bus_dom_i) begin
              cnt_q <= '0;
              st_q <= (cnt_q >= MIN_V) ? W_REC : W_IDLE;
            end else if (cnt_q >= MAX_V) begin
              st_q <= W_IDLE;
            end
          end
          W_REC: begin
            if (bus_dom_i) begin
              cnt_q <= '0;
              st_q <= (cnt_q >= MIN_V) ? W_DOM2 : W_DOM1;
            end else if (cnt_q >= MAX_V) begin
              st_q <= W_IDLE;
            end
          end
          W_DOM2: begin
            if (!bus_dom_i) begin
              st_q <= W_IDLE;
            end else if (cnt_q >= MIN_V) begin
              wake_o <= 1'b1;
              st_q <= W_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : wake_detector

// File: rtl/can_mode_ctrl.sv
// CAN transceiver mode control with transmit gating and wake handling
//
// Behaviour
// - Start in off mode after power up
// - Off mode selectable in every system mode except fail-safe
// - Off mode ignores all bus wake activity
// - Normal mode entered only by a command
// - Normal mode only in system normal mode
// - Transmitter held off for enable interval
// - Low present at interval end not driven
// - Driver follows transmit input in normal
// - Receiver drives receive output, low dominant
// - Paths carry streams up to 5 Mbaud
// - Flexible data rate traffic tolerated
// - Separate receive-only mode provided
// - Wake pattern in wake mode raises event
// - Wake mode set before sleep entry; code never sets it, sleep drops normal and receive-only to off
// - Receive-only disables driver, keeps reception
// - Receive output low after wake until change
// - Mode reads wake encoding after wake
// - Fail-safe forces wake-capable mode
`timescale 1ns/1ps
module can_mode_ctrl #(
  parameter int TX_EN_CYCLES = can_mode_pkg::TX_EN_CYC,
  parameter int WAKE_MIN_CYCLES = can_mode_pkg::WAKE_MIN_CYC,
  parameter int WAKE_MAX_CYCLES = can_mode_pkg::WAKE_MAX_CYC
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [can_mode_pkg::SYS_MODE_W-1:0] sys_mode_i,
  input wire logic mode_req_valid_i,
  input wire logic [1:0] mode_req_i,
  input wire logic can_transmit_input_i,
  input wire logic bus_recessive_i,
  output logic [1:0] mode_o,
  output logic mode_pending_o,
  output logic tx_open_o,
  output logic driver_dominant_o,
  output logic can_receive_output_o,
  output logic woken_o,
  output logic wake_valid_o,
  input wire logic wake_ready_i,
  output logic [can_mode_pkg::SYS_MODE_W-1:0] wake_sys_mode_o
);
  // ==========================================================================
  // Parameter checks
  if (TX_EN_CYCLES < 1 || TX_EN_CYCLES >= 65536) begin : g_bad_tx_en
    $error("TX_EN_CYCLES must lie in 1..65535");
  end
  if (WAKE_MIN_CYCLES < 1 || WAKE_MAX_CYCLES >= 65536 ||
      WAKE_MIN_CYCLES >= WAKE_MAX_CYCLES) begin : g_bad_wake
    $error("Wake bounds must satisfy 1 <= min < max < 65536");
  end

  localparam logic [can_mode_pkg::CNT_W-1:0] TX_EN_MAX =
    can_mode_pkg::CNT_W'(TX_EN_CYCLES);

  // ==========================================================================
  // Declarations
  can_mode_pkg::can_mode_t mode_q;
  can_mode_pkg::can_mode_t mode_prev_q;
  can_mode_pkg::can_mode_t req_q;
  can_mode_pkg::sys_mode_t sys_prev_q;
  can_mode_pkg::sys_mode_t sys_mode;
  can_mode_pkg::can_mode_t req_mode;
  logic req_pend_q;
  logic tx_meta_q;
  logic tx_sync_q;
  logic rx_meta_q;
  logic rx_sync_q;
  logic [can_mode_pkg::CNT_W-1:0] en_cnt_q;
  logic tx_open;
  logic armed_q;
  logic drive_q;
  logic rx_out_q;
  logic woken_q;
  logic evt_pend_q;
  logic [can_mode_pkg::SYS_MODE_W-1:0] evt_data_q;
  logic evt_ready;
  logic wake_hit;
  logic detect_en;
  logic mode_chg;
  logic rearm;

  assign sys_mode = can_mode_pkg::sys_mode_t'(sys_mode_i);
  assign req_mode = can_mode_pkg::can_mode_t'(mode_req_i);

  function automatic logic mode_allowed(input can_mode_pkg::can_mode_t m,
                                        input can_mode_pkg::sys_mode_t s);
    logic ok;
    ok = 1'b0;
    unique case (m)
      can_mode_pkg::CAN_OFF: ok = 1'b1;
      can_mode_pkg::CAN_WAKE: ok = 1'b1;
      can_mode_pkg::CAN_RXONLY: ok = (s == can_mode_pkg::SYS_NORMAL) ||
                                     (s == can_mode_pkg::SYS_STOP);
      can_mode_pkg::CAN_NORMAL: ok = (s == can_mode_pkg::SYS_NORMAL);
    endcase
    return ok;
  endfunction : mode_allowed

  // ==========================================================================
  // Pin synchronisers
  // two cycles of latency, 200 ns at this clock, as long as a whole 200 ns bit
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_meta_q <= 1'b1;
      tx_sync_q <= 1'b1;
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      tx_meta_q <= can_transmit_input_i;
      tx_sync_q <= tx_meta_q;
      rx_meta_q <= bus_recessive_i;
      rx_sync_q <= rx_meta_q;
    end
  end

  // ==========================================================================
  // Mode selection
  // off after reset
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= can_mode_pkg::RESET_MODE;
      req_q <= can_mode_pkg::RESET_MODE;
      req_pend_q <= 1'b0;
    end else begin
      if (sys_mode == can_mode_pkg::SYS_FAILSAFE) begin
        mode_q <= can_mode_pkg::CAN_WAKE;
        req_pend_q <= 1'b0;
      end else if (mode_req_valid_i) begin
        if (mode_allowed(req_mode, sys_mode)) begin
          mode_q <= req_mode;
          req_pend_q <= 1'b0;
        end else begin
          req_q <= req_mode;
          req_pend_q <= 1'b1;
          if (!mode_allowed(mode_q, sys_mode)) begin
            mode_q <= can_mode_pkg::CAN_OFF;
          end
        end
      end else if (req_pend_q && mode_allowed(req_q, sys_mode)) begin
        mode_q <= req_q;
        req_pend_q <= 1'b0;
      end else if (!mode_allowed(mode_q, sys_mode)) begin
        // a mode the system mode no longer allows falls back to off
        mode_q <= can_mode_pkg::CAN_OFF;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_prev_q <= can_mode_pkg::RESET_MODE;
      sys_prev_q <= can_mode_pkg::SYS_NORMAL;
    end else begin
      mode_prev_q <= mode_q;
      sys_prev_q <= sys_mode;
    end
  end

  assign mode_chg = (mode_q != mode_prev_q);
  // Wake ability comes back when entering stop or fail-safe
  assign rearm = (sys_mode != sys_prev_q) &&
                 ((sys_mode == can_mode_pkg::SYS_STOP) ||
                  (sys_mode == can_mode_pkg::SYS_FAILSAFE));

  // ==========================================================================
  // Enabling interval and transmit gating
  // restart on every normal entry
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_cnt_q <= '0;
    end else if (mode_q != can_mode_pkg::CAN_NORMAL) begin
      en_cnt_q <= '0;
    end else if (en_cnt_q != TX_EN_MAX) begin
      en_cnt_q <= en_cnt_q + 1'b1;
    end
  end

  // open only once the interval is over
  assign tx_open = (mode_q == can_mode_pkg::CAN_NORMAL) && (en_cnt_q == TX_EN_MAX);

  // arm on a recessive input after the interval
  // an early low only passes after it returns high
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed_q <= 1'b0;
    end else if (!tx_open) begin
      armed_q <= 1'b0;
    end else if (tx_sync_q) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= (mode_q == can_mode_pkg::CAN_NORMAL) && armed_q && !tx_sync_q;
    end
  end

  // ==========================================================================
  // Wake detection
  // detector idle outside wake mode
  assign detect_en = (mode_q == can_mode_pkg::CAN_WAKE) && !woken_q;

  wake_detector #(
    .MIN_CYC(WAKE_MIN_CYCLES),
    .MAX_CYC(WAKE_MAX_CYCLES)
  ) u_wake (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .enable_i(detect_en),
    .bus_dom_i(!rx_sync_q),
    .wake_o(wake_hit)
  );

  // wake latched, set wins over clear
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      woken_q <= 1'b0;
    end else if (wake_hit && detect_en) begin
      woken_q <= 1'b1;
    end else if (mode_chg || rearm) begin
      woken_q <= 1'b0;
    end
  end

  // Event waits here until the buffer takes it; a new wake while it waits overwrites it
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_pend_q <= 1'b0;
      evt_data_q <= '0;
    end else if (wake_hit && detect_en) begin
      evt_pend_q <= 1'b1;
      evt_data_q <= sys_mode_i;
    end else if (evt_ready) begin
      evt_pend_q <= 1'b0;
    end
  end

  pair_buffer #(
    .WIDTH(can_mode_pkg::SYS_MODE_W),
    .DEPTH(2)
  ) u_evt_buf (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .in_valid_i(evt_pend_q),
    .in_ready_o(evt_ready),
    .in_data_i(evt_data_q),
    .out_valid_o(wake_valid_o),
    .out_ready_i(wake_ready_i),
    .out_data_o(wake_sys_mode_o)
  );

  // ==========================================================================
  // Receive output
  // level copied bit by bit, any frame format
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_out_q <= 1'b1;
    end else if (woken_q) begin
      rx_out_q <= 1'b0;
    end else if ((mode_q == can_mode_pkg::CAN_NORMAL) ||
                 (mode_q == can_mode_pkg::CAN_RXONLY)) begin
      rx_out_q <= rx_sync_q;
    end else begin
      rx_out_q <= 1'b1;
    end
  end

  assign mode_o = mode_q;
  assign mode_pending_o = req_pend_q;
  assign tx_open_o = tx_open;
  assign driver_dominant_o = drive_q;
  assign can_receive_output_o = rx_out_q;
  assign woken_o = woken_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  off_stays_off_a: assert property (
    (mode_q == can_mode_pkg::CAN_OFF) && !mode_req_valid_i && !req_pend_q &&
    (sys_mode != can_mode_pkg::SYS_FAILSAFE) |=> (mode_q == can_mode_pkg::CAN_OFF))
    else $error("Left off mode without a command");

  off_request_a: assert property (
    mode_req_valid_i && (req_mode == can_mode_pkg::CAN_OFF) &&
    (sys_mode != can_mode_pkg::SYS_FAILSAFE) |=> (mode_q == can_mode_pkg::CAN_OFF))
    else $error("Off request not taken");

  off_no_wake_a: assert property (
    (mode_q == can_mode_pkg::CAN_OFF) |=> !woken_q && !$rose(evt_pend_q))
    else $error("Wake raised in off mode");

  normal_sys_a: assert property (
    (mode_q == can_mode_pkg::CAN_NORMAL) |-> ($past(sys_mode) == can_mode_pkg::SYS_NORMAL))
    else $error("Normal mode outside system normal");

  tx_closed_a: assert property (
    !tx_open |=> !driver_dominant_o)
    else $error("Driver active during enable interval");

  first_dom_a: assert property (
    $rose(tx_open) && !tx_sync_q |=> !driver_dominant_o [*2])
    else $error("Standing low reached the bus");

  follow_tx_a: assert property (
    (mode_q == can_mode_pkg::CAN_NORMAL) && armed_q |=> (driver_dominant_o == !$past(tx_sync_q)))
    else $error("Driver does not follow transmit input");

  rx_path_a: assert property (
    ((mode_q == can_mode_pkg::CAN_NORMAL) || (mode_q == can_mode_pkg::CAN_RXONLY)) && !woken_q
    |=> (can_receive_output_o == $past(rx_sync_q)))
    else $error("Receive output not following bus");

  rxonly_quiet_a: assert property (
    (mode_q == can_mode_pkg::CAN_RXONLY) |=> !driver_dominant_o)
    else $error("Driver active in receive-only");

  wake_event_a: assert property (
    wake_hit && detect_en |=> woken_q && evt_pend_q)
    else $error("Wake pattern not recorded");

  rx_low_a: assert property (
    woken_q |=> !can_receive_output_o)
    else $error("Receive output not low after wake");

  // A mode change in the same edge as the wake clears the flag one cycle later
  wake_read_a: assert property (
    woken_q && !mode_chg |-> (mode_o == 2'h1))
    else $error("Mode readback lost wake encoding");

  failsafe_wake_a: assert property (
    (sys_mode == can_mode_pkg::SYS_FAILSAFE) |=> (mode_q == can_mode_pkg::CAN_WAKE))
    else $error("Fail-safe did not force wake mode");

  timer_start_a: assert property (
    (mode_q == can_mode_pkg::CAN_NORMAL) && ($past(mode_q) != can_mode_pkg::CAN_NORMAL)
    |-> (en_cnt_q == '0))
    else $error("Interval counter not restarted");

  pend_hold_a: assert property (
    mode_req_valid_i && !mode_allowed(req_mode, sys_mode) &&
    (sys_mode != can_mode_pkg::SYS_FAILSAFE) |=> req_pend_q && (mode_q != $past(req_mode)))
    else $error("Disallowed request not held pending");

  normal_tx_c: cover property (tx_open ##1 driver_dominant_o);
  wake_seen_c: cover property (detect_en ##1 woken_q);
  pend_apply_c: cover property (req_pend_q ##1 !req_pend_q && !mode_req_valid_i);
  buf_full_c: cover property (evt_pend_q && !evt_ready);

endmodule : can_mode_ctrl

// File: tb/can_ctrl_model.sv
// Protocol controller model driving the transmit pin
`timescale 1ns/1ps
module can_ctrl_model (
  input wire logic mclk_i,
  input wire logic tx_open_i,
  input wire logic go_i,
  input wire logic [1:0] style_i,
  input wire logic [7:0] frame_i,
  output logic txd_o,
  output logic sending_o
);
  integer i;
  initial begin
    txd_o = 1'b1;
    sending_o = 1'b0;
    forever begin
      @(posedge mclk_i);
      if (go_i === 1'b1) begin
        #1;
        if (style_i == 2'h1) begin
          txd_o = 1'b0;
          repeat (2) @(posedge mclk_i);
          #1 txd_o = 1'b1;
        end
        // Faulty style: low held across interval end
        if (style_i == 2'h2) txd_o = 1'b0;
        // high until interval ends
        // Looked at off the edge, so the open flag has settled
        for (i = 0; i < 1000 && tx_open_i !== 1'b1; i++) begin
          @(posedge mclk_i);
          #1;
        end
        if (style_i == 2'h2) begin
          repeat (5) @(posedge mclk_i);
          #1 txd_o = 1'b1;
        end
        repeat (3) @(posedge mclk_i);
        sending_o = 1'b1;
        // Two cycles a bit, 5 Mbaud at this clock
        for (i = 7; i >= 0; i--) begin
          #1 txd_o = frame_i[i];
          repeat (2) @(posedge mclk_i);
        end
        #1 txd_o = 1'b1;
        repeat (4) @(posedge mclk_i);
        sending_o = 1'b0;
      end
    end
  end
endmodule : can_ctrl_model

// File: tb/hs_can_transceiver_mode_control_tb.sv
// Self-checking bench of the CAN transceiver mode control
`timescale 1ns/1ps
module hs_can_transceiver_mode_control_tb;
  localparam int TXC = 4;
  typedef struct {logic [2:0] sys; logic [1:0] req; logic [1:0] m; logic p;} row_t;
  logic mclk_i, resetn_i, mode_req_valid_i, bus_recessive_i, wake_ready_i, go, sending;
  logic [2:0] sys_mode_i, wake_sys_mode_o;
  logic [1:0] mode_req_i, mode_o, style;
  logic tx, mode_pending_o, tx_open_o, driver_dominant_o, can_receive_output_o;
  logic woken_o, wake_valid_o, cmp_tx, cmp_rx, no_drv;
  logic [2:0] th = 3'h7;
  logic [2:0] bh = 3'h7;
  int err_total, n_checks, k;
  row_t rows [8];
  can_mode_ctrl #(.TX_EN_CYCLES(TXC), .WAKE_MIN_CYCLES(2), .WAKE_MAX_CYCLES(20)) u_can_mode_ctrl (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .sys_mode_i(sys_mode_i),
    .mode_req_valid_i(mode_req_valid_i), .mode_req_i(mode_req_i),
    .can_transmit_input_i(tx), .bus_recessive_i(bus_recessive_i), .mode_o(mode_o),
    .mode_pending_o(mode_pending_o), .tx_open_o(tx_open_o),
    .driver_dominant_o(driver_dominant_o), .can_receive_output_o(can_receive_output_o),
    .woken_o(woken_o), .wake_valid_o(wake_valid_o), .wake_ready_i(wake_ready_i),
    .wake_sys_mode_o(wake_sys_mode_o));
  can_ctrl_model u_can_ctrl_model (.mclk_i(mclk_i), .tx_open_i(tx_open_o), .go_i(go),
    .style_i(style), .frame_i(8'h5b), .txd_o(tx), .sending_o(sending));
  // ==========================================================================
  // Clock and helpers
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  task tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task req(input logic [1:0] m);
    mode_req_valid_i = 1'b1;
    mode_req_i = m;
    tick(1);
    mode_req_valid_i = 1'b0;
  endtask : req
  task wait_for(input int bound, inout int n);
    for (n = 0; n < bound && tx_open_o !== 1'b1; n++) tick(1);
    if (n == bound) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, tx_open_o, 1'b1);
      give_verdict();
    end
  endtask : wait_for
  task wait_send(input logic lvl, input int bound);
    int n;
    for (n = 0; n < bound && sending !== lvl; n++) tick(1);
    if (n == bound) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, sending, lvl);
      give_verdict();
    end
  endtask : wait_send
  task wake_pattern;
    bus_recessive_i = 1'b0;
    tick(4);
    bus_recessive_i = 1'b1;
    tick(4);
    bus_recessive_i = 1'b0;
    tick(4);
    bus_recessive_i = 1'b1;
    tick(8);
  endtask : wake_pattern
  // Pins reach outputs three cycles later, so compare against a history
  always @(negedge mclk_i) begin
    if (cmp_tx) chk(driver_dominant_o, !th[2]);
    if (cmp_rx) chk(can_receive_output_o, bh[2]);
    if (driver_dominant_o === 1'b1 && (tx_open_o !== 1'b1 || no_drv)) chk(1, 0);
    th <= {th[1:0], tx};
    bh <= {bh[1:0], bus_recessive_i};
  end
  // ==========================================================================
  // Main sequence
  initial begin
    resetn_i = 1'b0; sys_mode_i = 3'h0; mode_req_valid_i = 1'b0; mode_req_i = 2'h0;
    bus_recessive_i = 1'b1; wake_ready_i = 1'b0; go = 1'b0; style = 2'h0;
    cmp_tx = 1'b0; cmp_rx = 1'b0; no_drv = 1'b0;
    err_total = 0; n_checks = 0;
    rows = '{'{3'h0, 2'h3, 2'h3, 1'b0}, '{3'h1, 2'h3, 2'h0, 1'b1},
             '{3'h1, 2'h2, 2'h2, 1'b0}, '{3'h1, 2'h1, 2'h1, 1'b0},
             '{3'h2, 2'h2, 2'h1, 1'b1}, '{3'h3, 2'h0, 2'h0, 1'b0},
             '{3'h4, 2'h0, 2'h1, 1'b0}, '{3'h0, 2'h2, 2'h2, 1'b0}};
    tick(2);
    chk({mode_o, driver_dominant_o, can_receive_output_o, woken_o, wake_valid_o},
        8'h04);
    resetn_i = 1'b1;
    tick(1);
    chk(mode_o, 2'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      sys_mode_i = rows[i].sys;
      req(rows[i].req);
      tick(2);
      chk({mode_o, mode_pending_o}, {rows[i].m, rows[i].p});
    end
    $display("test mode table done");
    // pending normal applied on return to system normal
    sys_mode_i = 3'h1;
    req(2'h3);
    tick(3);
    chk({mode_o, mode_pending_o}, 3'h5);
    sys_mode_i = 3'h0;
    tick(3);
    chk({mode_o, mode_pending_o}, 3'h6);
    req(2'h0);
    tick(2);
    $display("test pending done");
    // interval length with early low from the controller
    style = 2'h1;
    go = 1'b1;
    req(2'h3);
    go = 1'b0;
    wait_for(100, k);
    chk(k, TXC);
    wait_send(1'b1, 10);
    cmp_tx = 1'b1;
    wait_send(1'b0, 40);
    cmp_tx = 1'b0;
    $display("test transmit done");
    // low held across interval end never driven, re-entry restarts count
    req(2'h0);
    tick(2);
    style = 2'h2;
    go = 1'b1;
    no_drv = 1'b1;
    req(2'h3);
    go = 1'b0;
    wait_for(100, k);
    chk(k, TXC);
    tick(6);
    no_drv = 1'b0;
    wait_send(1'b1, 10);
    cmp_tx = 1'b1;
    wait_send(1'b0, 40);
    cmp_tx = 1'b0;
    $display("test held low done");
    // reception in normal and receive-only, driver off in receive-only
    cmp_rx = 1'b1;
    for (k = 0; k < 12; k++) begin
      bus_recessive_i = k[1];
      tick(1);
    end
    req(2'h2);
    tick(4);
    for (k = 0; k < 12; k++) begin
      bus_recessive_i = k[0];
      tick(1);
    end
    cmp_rx = 1'b0;
    bus_recessive_i = 1'b1;
    $display("test receive done");
    // wake pattern ignored in off mode
    req(2'h0);
    tick(2);
    wake_pattern();
    chk({woken_o, wake_valid_o, can_receive_output_o}, 3'h1);
    // wake raises event, receive output low, mode stays wake
    req(2'h1);
    tick(2);
    wake_pattern();
    chk({woken_o, wake_valid_o, can_receive_output_o, mode_o}, 5'h19);
    chk(wake_sys_mode_o, 3'h0);
    // Second event while the consumer stalls
    req(2'h0);
    tick(2);
    chk(woken_o, 1'b0);
    sys_mode_i = 3'h1;
    req(2'h1);
    tick(2);
    wake_pattern();
    chk({woken_o, wake_valid_o}, 2'h3);
    wake_ready_i = 1'b1;
    tick(1);
    chk({wake_valid_o, wake_sys_mode_o}, 4'h9);
    tick(1);
    chk(wake_valid_o, 1'b0);
    wake_ready_i = 1'b0;
    sys_mode_i = 3'h0;
    req(2'h2);
    tick(3);
    chk({woken_o, mode_o}, 3'h2);
    $display("test wake done");
    give_verdict();
  end
endmodule : hs_can_transceiver_mode_control_tb
